//--- design/edoc_ctrl.sv
// edoc_ctrl: edo dimm memory controller, line transfers to buffered dimm pairs
// assumes synchronous processor inputs and external transceivers steered by half_sel_o
// Operation
// [R1] row then column share one 12-bit address bus
// [R2] eight row strobes, two column strobes, one write enable driven
// [R3] 144-bit dram word moves as two successive 72-bit halves
// [R4] check bits generated on writes and checked on reads, always
// [R5] strobe timing meets 60 ns edo parts
// [R6] one column-width setting, 10 or 11 bits, for all memory
// [R7] 11-bit mode halves addressable dimm pairs to four dimms
// [R8] memory is 1 gbyte contiguous from address zero
// [R9] every transfer moves one full 64-byte line
// [R10] non-cacheable request is not performed and flags an error
// [R11] address bits 28:27 pick the dimm pair
// [R12] address bit 29 picks bottom or top stack
// [R13] bits 29:27 decode to exactly one active-low row strobe
// [R14] bank map: 0x0, 0x1000_0000, 0x2000_0000, 0x3000_0000
// [R15] refresh is column strobes before row strobes
// [R16] line address split into row and column by column-width
`timescale 1ns/1ps
`include "edoc_defs.svh"
module edoc_ctrl (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic col11_mode_i,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_cacheable_i,
  input wire logic [`EDOC_PA_W-1:0] phys_addr_i,
  input wire logic refresh_req_i,
  input wire logic [`EDOC_HALF_W-1:0] wdata_i,
  input wire logic [`EDOC_HALF_W-1:0] rdata_i,
  output logic busy_o,
  output logic done_o,
  output logic err_noncache_o,
  output logic err_ecc_o,
  output logic wdata_take_o,
  output logic rdata_valid_o,
  output logic half_sel_o,
  output logic [`EDOC_HALF_W-1:0] mem_wdata_o,
  output logic [`EDOC_ADDR_W-1:0] dram_addr_o,
  output logic [3:0] bottom_stack_row_strobe_n_o,
  output logic [3:0] top_stack_row_strobe_n_o,
  output logic [`EDOC_CAS_N-1:0] col_strobe_n_o,
  output logic write_en_n_o
);
  localparam logic [3:0] RCD_CYC = 4'(`EDOC_RCD_CYC);
  localparam logic [3:0] CAS_CYC = 4'(`EDOC_CAS_CYC);
  localparam logic [3:0] CP_CYC = 4'(`EDOC_CP_CYC);
  localparam logic [3:0] RP_CYC = 4'(`EDOC_RP_CYC);
  localparam logic [3:0] CSR_CYC = 4'(`EDOC_CSR_CYC);
  localparam logic [3:0] RAS_CYC = 4'(`EDOC_RAS_CYC);

  edoc_pkg::edoc_state_t state;
  logic [3:0] tmr;
  logic [2:0] beat;
  logic wr;
  logic [`EDOC_PA_W-1:0] addr;
  logic [`EDOC_RAS_N-1:0] ras_sel_n;
  logic [`EDOC_ADDR_W-1:0] row_addr;
  logic [`EDOC_ADDR_W-1:0] col_addr;
  logic [`EDOC_CHK_W-1:0] gen_chk;
  logic [`EDOC_CHK_W-1:0] rd_chk;
  logic tmr_done;
  logic addr_ok;

  // check bits over the low 64 data bits of each half; upper 8 lanes carry them
  edoc_ecc u_wgen (
    .data_i(wdata_i[`EDOC_DATA_W-1:0]),
    .chk_o(gen_chk)
  );
  edoc_ecc u_rchk (
    .data_i(rdata_i[`EDOC_DATA_W-1:0]),
    .chk_o(rd_chk)
  );

  assign tmr_done = (tmr == 4'h0);
  // whole 1 gbyte map from zero; 11-bit mode reaches pairs 0 and 2 only
  assign addr_ok = !col11_mode_i || !addr[`EDOC_PA_PAIR_LO]; // R8 R7

  // pair from 28:27, stack from 29, one strobe per stack per pair
  always_comb begin
    ras_sel_n = {`EDOC_RAS_N{1'b1}}; // R14
    ras_sel_n[{addr[`EDOC_PA_STACK], addr[`EDOC_PA_PAIR_HI:`EDOC_PA_PAIR_LO]}] = 1'b0; // R11 R12 R13
  end

  // row/column split: 10-bit mode uses 10 column bits, 11-bit mode one more; line offset dropped
  always_comb begin
    if (col11_mode_i) begin
      col_addr = {1'b0, addr[14:6], beat[1:0]}; // R16 R6
      row_addr = addr[26:15];
    end else begin
      col_addr = {2'h0, addr[13:6], beat[1:0]}; // R16
      row_addr = addr[25:14]; // bit 26 unused: 10-bit parts top out at a smaller pair
    end
  end

  // the sequencer: one line is four 144-bit beats in edo page mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= edoc_pkg::ST_IDLE;
      tmr <= 4'h0;
      beat <= 3'h0;
      wr <= 1'b0;
      addr <= '0;
    end else begin
      if (!tmr_done) begin
        tmr <= tmr - 4'h1;
      end
      unique case (state)
        edoc_pkg::ST_IDLE: begin
          // refresh wins over a pending request so rows are never starved
          if (refresh_req_i) begin
            state <= edoc_pkg::ST_CSR;
            tmr <= CSR_CYC;
          end else if (req_i && req_cacheable_i) begin // R10
            state <= edoc_pkg::ST_ROW;
            wr <= req_write_i;
            addr <= phys_addr_i;
            beat <= 3'h0;
          end
        end
        edoc_pkg::ST_ROW: begin
          state <= edoc_pkg::ST_RCD;
          tmr <= RCD_CYC; // R5
        end
        edoc_pkg::ST_RCD: begin
          if (tmr_done) begin
            state <= addr_ok ? edoc_pkg::ST_CAS : edoc_pkg::ST_PRE;
            tmr <= CAS_CYC;
          end
        end
        edoc_pkg::ST_CAS: begin
          if (tmr_done) begin
            beat <= beat + 3'h1;
            tmr <= CP_CYC;
            state <= (beat == 3'(`EDOC_BEATS - 1)) ? edoc_pkg::ST_PRE : edoc_pkg::ST_CP; // R9
          end
        end
        edoc_pkg::ST_CP: begin
          if (tmr_done) begin
            state <= edoc_pkg::ST_CAS;
            tmr <= CAS_CYC;
          end
        end
        edoc_pkg::ST_PRE: begin
          if (tmr_done) begin
            state <= edoc_pkg::ST_IDLE;
          end
          if (state != edoc_pkg::ST_PRE || tmr == 4'h0) begin
            tmr <= 4'h0;
          end
        end
        edoc_pkg::ST_CSR: begin
          if (tmr_done) begin
            state <= edoc_pkg::ST_RFRAS;
            tmr <= RAS_CYC;
          end
        end
        edoc_pkg::ST_RFRAS: begin
          if (tmr_done) begin
            state <= edoc_pkg::ST_PRE;
            tmr <= RP_CYC;
          end
        end
      endcase
      // precharge always lasts the full row-precharge time
      if ((state == edoc_pkg::ST_CAS && tmr_done && beat == 3'(`EDOC_BEATS - 1)) ||
          (state == edoc_pkg::ST_RCD && tmr_done && !addr_ok)) begin
        tmr <= RP_CYC; // R5
      end
    end
  end

  // dram pins, registered straight from the sequence state
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dram_addr_o <= '0;
      bottom_stack_row_strobe_n_o <= 4'hf;
      top_stack_row_strobe_n_o <= 4'hf;
      col_strobe_n_o <= '1;
      write_en_n_o <= 1'b1;
    end else begin
      unique case (state)
        edoc_pkg::ST_ROW: begin
          dram_addr_o <= row_addr; // R1
          bottom_stack_row_strobe_n_o <= ras_sel_n[3:0]; // R2 R13
          top_stack_row_strobe_n_o <= ras_sel_n[7:4];
        end
        edoc_pkg::ST_RCD, edoc_pkg::ST_CP: begin
          dram_addr_o <= col_addr; // R1 R16
          col_strobe_n_o <= '1;
          write_en_n_o <= !(wr && addr_ok);
        end
        edoc_pkg::ST_CAS: begin
          col_strobe_n_o <= {`EDOC_CAS_N{!addr_ok}};
        end
        edoc_pkg::ST_CSR: begin
          col_strobe_n_o <= '0; // R15
          write_en_n_o <= 1'b1;
        end
        edoc_pkg::ST_RFRAS: begin
          bottom_stack_row_strobe_n_o <= 4'h0; // R15
          top_stack_row_strobe_n_o <= 4'h0;
        end
        default: begin
          bottom_stack_row_strobe_n_o <= 4'hf;
          top_stack_row_strobe_n_o <= 4'hf;
          col_strobe_n_o <= '1;
          write_en_n_o <= 1'b1;
        end
      endcase
    end
  end

  // processor side: two 72-bit halves per 144-bit beat, ecc in lanes 71:64
  // one half per column strobe cycle; precharge cycles between beats move nothing
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      err_noncache_o <= 1'b0;
      err_ecc_o <= 1'b0;
      wdata_take_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      half_sel_o <= 1'b0;
      mem_wdata_o <= '0;
    end else begin
      busy_o <= (state != edoc_pkg::ST_IDLE);
      done_o <= (state == edoc_pkg::ST_PRE) && tmr_done;
      err_noncache_o <= (state == edoc_pkg::ST_IDLE) && !refresh_req_i &&
                        req_i && !req_cacheable_i; // R10
      err_ecc_o <= 1'b0;
      wdata_take_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      if (state == edoc_pkg::ST_CAS) begin
        half_sel_o <= !half_sel_o; // R3
        if (wr) begin
          wdata_take_o <= 1'b1;
          mem_wdata_o <= {gen_chk, wdata_i[`EDOC_DATA_W-1:0]}; // R4
        end else begin
          rdata_valid_o <= 1'b1;
          err_ecc_o <= (rd_chk != rdata_i[`EDOC_HALF_W-1:`EDOC_DATA_W]); // R4
        end
      end else begin
        half_sel_o <= 1'b0;
      end
    end
  end

  a_one_row_strobe: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
    (state == edoc_pkg::ST_RCD) |-> $countones(~{top_stack_row_strobe_n_o,
    bottom_stack_row_strobe_n_o}) == 1) else $error("row strobe not one-hot"); // R13
  a_refresh_order: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
    $fell(bottom_stack_row_strobe_n_o[0]) && (state == edoc_pkg::ST_RFRAS) |->
    col_strobe_n_o == '0) else $error("refresh row strobe before column strobe"); // R15
  a_noncache_err: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
    (state == edoc_pkg::ST_IDLE && !refresh_req_i && req_i && !req_cacheable_i) |=>
    err_noncache_o && busy_o == 1'b0) else $error("non-cacheable not flagged"); // R10
  a_rcd_delay: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
    (state == edoc_pkg::ST_ROW) |=> !(state == edoc_pkg::ST_CAS) [*4])
    else $error("column strobe too soon after row"); // R5
  a_line_beats: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
    (state == edoc_pkg::ST_PRE && $past(state) == edoc_pkg::ST_CAS) |->
    beat == 3'(`EDOC_BEATS)) else $error("line not four beats"); // R9
  a_stack_pick: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
    (state == edoc_pkg::ST_RCD && addr[`EDOC_PA_STACK]) |->
    bottom_stack_row_strobe_n_o == 4'hf) else $error("wrong stack strobed"); // R12
  a_pair_pick: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
    (state == edoc_pkg::ST_RCD && !addr[`EDOC_PA_STACK]) |->
    !bottom_stack_row_strobe_n_o[addr[`EDOC_PA_PAIR_HI:`EDOC_PA_PAIR_LO]])
    else $error("wrong pair strobed"); // R11
  a_col11_reach: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
    (state == edoc_pkg::ST_RCD && col11_mode_i && addr[`EDOC_PA_PAIR_LO]) |=>
    col_strobe_n_o == '1) else $error("odd pair accessed in 11-bit mode"); // R7

  // a column cycle without an open row would strobe a closed page
  a_cas_row_open: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
    (state == edoc_pkg::ST_CAS) |->
    {top_stack_row_strobe_n_o, bottom_stack_row_strobe_n_o} != 8'hff)
    else $error("column cycle with no open row");
  // data pulses come only from column strobe cycles
  a_data_in_cas: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    (wdata_take_o || rdata_valid_o) |-> $past(state) == edoc_pkg::ST_CAS)
    else $error("data pulse outside a column cycle");
  // the first half of every beat goes out with the half select raised
  a_half_first: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    (state == edoc_pkg::ST_CAS && $past(state) != edoc_pkg::ST_CAS) |=>
    half_sel_o && (wdata_take_o || rdata_valid_o))
    else $error("first half not selected");
  // row address on the shared bus in the cycle the row strobe falls
  a_row_addr_out: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
    (state == edoc_pkg::ST_ROW) |=> dram_addr_o == $past(row_addr))
    else $error("row address not on the bus");
  // column address stands while the column strobe is low
  a_col_addr_out: assert property (@(posedge mclk_i) disable iff (rst_i) // R16
    (state == edoc_pkg::ST_CAS) |-> dram_addr_o == col_addr)
    else $error("column address not on the bus");
  // refresh keeps column strobes low and never writes
  a_refresh_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
    (state == edoc_pkg::ST_RFRAS) |-> write_en_n_o && col_strobe_n_o == '0)
    else $error("refresh without column strobes held");
  // a non-cacheable request never opens a row
  a_noncache_idle: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
    err_noncache_o |-> {top_stack_row_strobe_n_o, bottom_stack_row_strobe_n_o} == 8'hff)
    else $error("non-cacheable request reached the dimms");
endmodule : edoc_ctrl

//--- design/edoc_defs.svh
// edoc_defs.svh: offsets, field positions and timing counts of the edo memory controller
// assumes a 100 mhz system clock; included by bare name
`ifndef EDOC_DEFS_SVH
`define EDOC_DEFS_SVH
`define EDOC_ADDR_W 12
`define EDOC_RAS_N 8
`define EDOC_CAS_N 2
`define EDOC_HALF_W 72
`define EDOC_WIDE_W 144
`define EDOC_DATA_W 64
`define EDOC_CHK_W 8
`define EDOC_LINE_BYTES 64
`define EDOC_BEATS 4
`define EDOC_PA_W 30
`define EDOC_PA_STACK 29
`define EDOC_PA_PAIR_HI 28
`define EDOC_PA_PAIR_LO 27
`define EDOC_CLK_NS 10
`define EDOC_T_RCD_NS 45
`define EDOC_T_CAS_NS 10
`define EDOC_T_CP_NS 10
`define EDOC_T_RP_NS 40
`define EDOC_T_CSR_NS 10
`define EDOC_T_RAS_NS 60
`define EDOC_CYC(ns) (((ns) + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
`define EDOC_RCD_CYC `EDOC_CYC(`EDOC_T_RCD_NS)
`define EDOC_CAS_CYC `EDOC_CYC(`EDOC_T_CAS_NS)
`define EDOC_CP_CYC `EDOC_CYC(`EDOC_T_CP_NS)
`define EDOC_RP_CYC `EDOC_CYC(`EDOC_T_RP_NS)
`define EDOC_CSR_CYC `EDOC_CYC(`EDOC_T_CSR_NS)
`define EDOC_RAS_CYC `EDOC_CYC(`EDOC_T_RAS_NS)
`endif

//--- design/edoc_ecc.sv
// edoc_ecc: check-bit generator for one 64-bit data word
// assumes purely combinational use inside the controller
`timescale 1ns/1ps
`include "edoc_defs.svh"
module edoc_ecc (
  input wire logic [`EDOC_DATA_W-1:0] data_i,
  output logic [`EDOC_CHK_W-1:0] chk_o
);
  // each check bit is parity over a distinct rotating subset; catches all single-bit faults
  genvar g;
  generate
    for (g = 0; g < `EDOC_CHK_W; g++) begin : g_chk
      logic [`EDOC_DATA_W-1:0] mask;
      always_comb begin
        mask = '0;
        for (int b = 0; b < `EDOC_DATA_W; b++) begin
          mask[b] = ((b >> (g % 6)) & 1) == 1 || (b % `EDOC_CHK_W) == g;
        end
        chk_o[g] = ^(data_i & mask);
      end
    end
  endgenerate
endmodule : edoc_ecc

//--- design/edoc_pkg.sv
// edoc_pkg: types of the edo memory controller
// assumes edoc_defs.svh supplies the numbers
package edoc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ROW, ST_RCD, ST_CAS, ST_CP, ST_PRE, ST_CSR, ST_RFRAS
  } edoc_state_t;
endpackage : edoc_pkg

//--- test/edoc_ctrl_tb.sv
// edoc_ctrl_tb: self-checking bench of the edo dimm memory controller
// assumes the dimm model behind the transceivers; inputs move 1 ns after rising edges
`timescale 1ns/1ps
`include "edoc_defs.svh"
module edoc_ctrl_tb;
  logic mclk_i = 0, rst_i = 1, col11_mode_i = 0, req_i = 0, req_write_i = 0;
  logic req_cacheable_i = 0, refresh_req_i = 0, corrupt = 0;
  logic [29:0] phys_addr_i = 30'h0;
  logic [71:0] wdata_i = 72'h0, rdata_i;
  logic busy_o, done_o, err_noncache_o, err_ecc_o, wdata_take_o, rdata_valid_o, half_sel_o;
  logic [71:0] mem_wdata_o, wd_last;
  logic [11:0] dram_addr_o, row_addr, col_first;
  logic [3:0] bot_n, top_n;
  logic [1:0] col_strobe_n_o;
  logic write_en_n_o;
  logic [7:0] ras_acc;
  int fails = 0, checked = 0, n_take, n_val, n_ecc, n_nc, n_done, n_cas, t = 0, t_ras, t_cas;
  int n_we, n_hs;

  edoc_ctrl dut (.mclk_i(mclk_i), .rst_i(rst_i), .col11_mode_i(col11_mode_i), .req_i(req_i),
    .req_write_i(req_write_i), .req_cacheable_i(req_cacheable_i), .phys_addr_i(phys_addr_i),
    .refresh_req_i(refresh_req_i), .wdata_i(wdata_i), .rdata_i(rdata_i), .busy_o(busy_o),
    .done_o(done_o), .err_noncache_o(err_noncache_o), .err_ecc_o(err_ecc_o),
    .wdata_take_o(wdata_take_o), .rdata_valid_o(rdata_valid_o), .half_sel_o(half_sel_o),
    .mem_wdata_o(mem_wdata_o), .dram_addr_o(dram_addr_o),
    .bottom_stack_row_strobe_n_o(bot_n), .top_stack_row_strobe_n_o(top_n),
    .col_strobe_n_o(col_strobe_n_o), .write_en_n_o(write_en_n_o));
  edoc_dimm_model dimm (.mclk_i(mclk_i), .bottom_stack_row_strobe_n_i(bot_n),
    .top_stack_row_strobe_n_i(top_n), .corrupt_i(corrupt), .rdata_o(rdata_i));

  // 100 mhz clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // monitor: pulse counts, first row strobe and its address, first column strobe
  always @(posedge mclk_i) begin
    t++;
    n_take += (wdata_take_o === 1'b1);
    n_val += (rdata_valid_o === 1'b1);
    n_ecc += (err_ecc_o === 1'b1);
    n_nc += (err_noncache_o === 1'b1);
    n_done += (done_o === 1'b1);
    n_cas += (col_strobe_n_o !== 2'b11);
    if (~{top_n, bot_n} != 8'h0 && ras_acc == 8'h0) begin
      t_ras = t;
      row_addr = dram_addr_o;
    end
    ras_acc |= ~{top_n, bot_n};
    n_we += (write_en_n_o === 1'b0);
    n_hs += (half_sel_o === 1'b1 && (wdata_take_o === 1'b1 || rdata_valid_o === 1'b1));
    if (wdata_take_o === 1'b1) wd_last = mem_wdata_o;
    // first column address seen with the first column strobe
    if (col_strobe_n_o !== 2'b11 && t_cas < 0) begin
      t_cas = t;
      col_first = dram_addr_o;
    end
  end

  task automatic summarize();
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one request held for hold edges, then a bounded wait for done and idle
  task automatic go(input logic wr, cach, rf, input logic [29:0] pa, input int hold);
    int i;
    n_take = 0; n_val = 0; n_ecc = 0; n_nc = 0; n_done = 0; n_cas = 0;
    ras_acc = 8'h0; t_ras = -1; t_cas = -1;
    n_we = 0; n_hs = 0;
    req_write_i = wr; req_cacheable_i = cach; phys_addr_i = pa;
    wdata_i = {8'h0, 34'h0, pa};
    refresh_req_i = rf; req_i = ~rf;
    repeat (hold) @(posedge mclk_i);
    #1 req_i = 0;
    refresh_req_i = 0;
    for (i = 0; i < 80 && (n_done == 0 || busy_o !== 1'b0); i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (cach && i == 80) begin
      fails++;
      $display("[ERR] done wait expected 1 seen 0");
      summarize();
    end
  endtask : go

  // every stack and pair code, read then written; strobe, address, beat counts
  task automatic s_map();
    logic [29:0] pa;
    for (int c = 0; c < 16; c++) begin
      pa = {c[3:1], 1'b0, 12'h5a0 + c[3:1], 14'h1234};
      go(c[0], 1, 0, pa, 1);
      chk("row strobe", 32'h1 << c[3:1], ras_acc);
      chk("row addr", 12'h5a0 + c[3:1], row_addr);
      chk("col addr", 12'h120, col_first);
      chk("half sel", 4, n_hs);
      chk("done", 1, n_done);
      chk("write en", c[0], n_we > 0);
      if (c[0]) chk("wdata", pa, wd_last[31:0]);
      chk("halves out", c[0] ? 8 : 0, n_take);
      chk("halves in", c[0] ? 0 : 8, n_val);
      chk("ecc err", 0, n_ecc);
      chk("rcd", 1, t_cas - t_ras >= `EDOC_RCD_CYC);
    end
  endtask : s_map

  // a flipped data bit in every half must be flagged
  task automatic s_ecc();
    corrupt = 1;
    go(0, 1, 0, 30'h0, 1);
    chk("ecc bad", 8, n_ecc);
    corrupt = 0;
    // a parity code gives zero check bits for zero data, nonzero for one set bit
    go(1, 1, 0, 30'h0, 1);
    chk("ecc zero", 8'h00, wd_last[71:64]);
    go(1, 1, 0, 30'h40, 1);
    chk("ecc one bit", 1, wd_last[71:64] != 8'h00);
  endtask : s_ecc

  // non-cacheable request held three idle cycles: three flags, no dram cycle
  task automatic s_noncache();
    go(1, 0, 0, 30'h0800_0000, 3);
    chk("nc err", 3, n_nc);
    chk("nc strobe", 0, ras_acc | n_cas);
  endtask : s_noncache

  // refresh: column strobe first, no data moves
  task automatic s_refresh();
    go(0, 1, 1, 30'h0, 1);
    chk("cbr order", 1, t_cas >= 0 && t_ras > t_cas);
    chk("cbr data", 0, n_take + n_val);
  endtask : s_refresh

  // 11-bit columns: odd pairs unreachable, even pairs move a full line
  task automatic s_col11();
    col11_mode_i = 1;
    go(1, 1, 0, 30'h0800_0000, 1);
    chk("c11 odd cas", 0, n_cas);
    chk("c11 odd strobe", 8'h02, ras_acc);
    go(1, 1, 0, {3'b010, 12'h3c5, 15'h4040}, 1);
    chk("c11 halves", 8, n_take);
    chk("c11 row", 12'h3c5, row_addr);
    chk("c11 col", 12'h404, col_first);
    col11_mode_i = 0;
  endtask : s_col11

  initial begin
    repeat (10) @(posedge mclk_i);
    #1 rst_i = 0;
    chk("idle strobes", 11'h7ff, {top_n, bot_n, col_strobe_n_o, write_en_n_o});
    s_map();
    s_ecc();
    s_noncache();
    s_refresh();
    s_col11();
    summarize();
  end
endmodule : edoc_ctrl_tb

//--- test/edoc_dimm_model.sv
// edoc_dimm_model: behavioural pair of buffered edo dimms seen through the transceivers
// assumes strobes change just after mclk_i edges; corrupt_i flips one data bit on reads
`timescale 1ns/1ps
`include "edoc_defs.svh"
module edoc_dimm_model (
  input wire logic mclk_i,
  input wire logic [3:0] bottom_stack_row_strobe_n_i,
  input wire logic [3:0] top_stack_row_strobe_n_i,
  input wire logic corrupt_i,
  output logic [`EDOC_HALF_W-1:0] rdata_o
);
  logic open_row;
  logic [`EDOC_HALF_W-1:0] junk = {36{2'b10}};
  // edo parts keep data out after the column strobe rises, so hold it while a row is open
  assign open_row = ~&{bottom_stack_row_strobe_n_i, top_stack_row_strobe_n_i};
  // a released bus flips every cycle so a late sample never sees stale data
  always_ff @(posedge mclk_i) begin
    junk <= ~junk;
  end
  // zero word with zero check bits; one bad data bit when corruption is asked for
  assign rdata_o = open_row ? {71'h0, corrupt_i} : junk;
endmodule : edoc_dimm_model
